//--- test/spss_host.sv
// host model holding the hard reset pin
`timescale 1ns/1ps
module spss_host #(parameter int HOLD = 40000) (
  input  wire logic sys_clk,
  input  wire logic go,
  output logic      hard_reset_n_pin
);
  int n = 0;
  initial hard_reset_n_pin = 1'h0;
  always @(posedge sys_clk) begin
    n <= go ? n + 1 : 0;
    hard_reset_n_pin <= go && n >= HOLD;
  end
endmodule

//--- test/spss_props.sv
// checker for the sequencer ports
`timescale 1ns/1ps
`include "spss_cfg.svh"
module spss_props #(parameter int INIT_CYC = 20, parameter int PLL_CYC = 10) (
  input wire logic sys_clk, resetn, hard_reset_n_pin, mode_we, stop_at_frame, row_end,
  input wire logic frame_end, pll_enable, streaming, soft_standby, init_busy, pix_oe_n,
  input wire logic [`SPSS_MODE_W-1:0] mode_wdata,
  input wire logic [`SPSS_PIX_W-1:0]  pix_data_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence go_req; soft_standby && mode_we && mode_wdata[2]; endsequence
  oe_off_a: assert property (!hard_reset_n_pin[*5] |-> pix_oe_n) else $error("pins on");
  init_len_a: assert property ($fell(init_busy) |-> soft_standby && $past(init_busy, INIT_CYC))
    else $error("init length");
  pll_on_a: assert property (go_req |-> ##1 !pll_enable ##1 pll_enable) else $error("no pll");
  lock_wait_a: assert property ($rose(pll_enable) |-> !streaming[*8]) else $error("early");
  lock_time_a: assert property ($rose(streaming) |-> $past(pll_enable, PLL_CYC))
    else $error("lock time");
  stream_hold_a: assert property (streaming && hard_reset_n_pin
    && !(stop_at_frame ? frame_end : row_end) |=> streaming) else $error("early stop");
  stop_end_a: assert property ($fell(streaming) && hard_reset_n_pin |-> soft_standby)
    else $error("no standby");
  quiet_out_a: assert property (!streaming[*2] |-> pix_data_out == 10'h000)
    else $error("data out");
endmodule

//--- test/test_spss_top.sv
// bench for the sequencer
`timescale 1ns/1ps
module test_spss_top;
  localparam int INIT = 20, PLL = 10;
  logic sys_clk = 1'h0, resetn = 1'h0, go = 1'h0, mode_we = 1'h0, stop_at_frame = 1'h0;
  logic row_end = 1'h0, frame_end = 1'h0, frame_valid_in = 1'h1, line_valid_in = 1'h1;
  logic hard_reset_n_pin, pll_enable, streaming, soft_standby, init_busy, pix_oe_n;
  logic [15:0] mode_wdata = 16'h0000, mode_rdata;
  logic [9:0]  pix_data_in = 10'h2a5, pix_data_out;
  int          n_mismatch = 0, total_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  spss_host host (.*);
  spss_top #(.INIT_CYC(INIT), .PLL_CYC(PLL)) dut (.*, .patch_rom_load(),
    .one_time_prog_memory_load(), .frame_valid_out(), .line_valid_out());
  task automatic chk(input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] d);
    mode_wdata = d;
    mode_we = 1'h1;
    tick(1);
    mode_we = 1'h0;
  endtask
  task automatic pulse(input logic r, f);
    row_end = r;
    frame_end = f;
    tick(1);
    row_end = 1'h0;
    frame_end = 1'h0;
    tick(1);
  endtask
  task automatic s_init;
    int n = 0;
    chk(pix_oe_n, 1'h1);
    go = 1'h1;
    for (int i = 0; !soft_standby; i++) begin
      if (i > 50000) begin
        chk(1'h0, 1'h1);
        complete_run;
      end
      n += init_busy;
      mode_we = init_busy;
      mode_wdata = 16'h0004;
      tick(1);
    end
    mode_we = 1'h0;
    chk(n, INIT);
    tick(3);
    chk(pll_enable, 1'h0);
    chk(mode_rdata, 16'h0000);
  endtask
  task automatic s_off;
    tick(8);
    go = 1'h0;
    tick(6);
    chk(pix_oe_n, 1'h1);
    chk(mode_rdata, 16'h0000);
    chk(streaming, 1'h0);
    tick(8);
  endtask
  task automatic s_start;
    int i;
    wr(16'h0004);
    chk(mode_rdata, 16'h0004);
    chk(pll_enable, 1'h0);
    tick(1);
    chk(pll_enable, 1'h1);
    for (i = 0; !streaming && i < 60; i++) tick(1);
    chk(i, PLL);
    pix_data_in = ~pix_data_in;
    tick(1);
    chk(pix_data_out, pix_data_in);
  endtask
  task automatic s_stop(input logic frm);
    stop_at_frame = frm;
    wr(16'h0000);
    tick(2);
    chk(streaming, 1'h1);
    pulse(1'h1, 1'h0);
    chk(soft_standby, !frm);
    pulse(1'h0, frm);
    chk(soft_standby, 1'h1);
  endtask
  initial begin
    tick(4);
    resetn = 1'h1;
    s_init;
    s_start;
    s_stop(1'h0);
    s_start;
    s_stop(1'h1);
    s_off;
    s_init;
    s_start;
    s_stop(1'h0);
    complete_run;
  end
endmodule
bind spss_top spss_props #(.INIT_CYC(INIT_CYC), .PLL_CYC(PLL_CYC)) props (.*);

//--- verilog/spss_cfg.svh
// timing constants and field positions for the sensor power and stream sequencer
`ifndef SPSS_CFG_SVH
`define SPSS_CFG_SVH
`define SPSS_CLK_HZ          40000000
`define SPSS_INIT_REF_CLKS   160000
`define SPSS_PLL_LOCK_US     1000
`define SPSS_PLL_LOCK_CYC    ((`SPSS_PLL_LOCK_US * (`SPSS_CLK_HZ / 1000000)))
`define SPSS_STREAM_BIT      2
`define SPSS_MODE_W          16
`define SPSS_PIX_W           10
`define SPSS_CNT_W           20
`endif

//--- verilog/spss_pkg.sv
// types for the sensor power and stream sequencer
package spss_pkg;
  typedef enum logic [2:0] {
    SPSS_HARD_RESET,
    SPSS_INIT,
    SPSS_STANDBY,
    SPSS_PLL_WAIT,
    SPSS_STREAMING,
    SPSS_DRAIN
  } spss_state_t;
endpackage

//--- verilog/spss_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module spss_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] dout_r;
  logic [W-1:0] dout_nxt;

  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
    if (!resetn) begin
      meta_nxt = '0;
      dout_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    meta_r <= meta_nxt;
    dout_r <= dout_nxt;
  end

  assign dout = dout_r;
endmodule

//--- verilog/spss_top.sv
// device-side power-up, reset, init and stream sequencing
`timescale 1ns/1ps
`include "spss_cfg.svh"

// Functional notes
// (RQ1) host powers rails in order, 100 us apart
// (RQ2) host starts reference clock after last rail
// (RQ3) host holds hard reset low 1 ms
// (RQ4) pixel outputs tri-stated during hard reset
// (RQ5) 160000 reference clocks of init, then standby
// (RQ6) stream bit set enables the PLL
// (RQ7) stream only after 1 ms PLL lock
// (RQ8) host clears stream bit before power-down
// (RQ9) stream clear finishes row or frame first
// (RQ10) host removes rails in reverse order
// (RQ11) host waits 100 ms before next power-up
// (RQ12) host waits one frame before removing supply
module spss_top
  import spss_pkg::*;
#(
  parameter int INIT_CYC = `SPSS_INIT_REF_CLKS,
  parameter int PLL_CYC  = `SPSS_PLL_LOCK_CYC
) (
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic                    hard_reset_n_pin,
  input  wire logic [`SPSS_MODE_W-1:0] mode_wdata,
  input  wire logic                    mode_we,
  input  wire logic                    stop_at_frame,
  input  wire logic                    row_end,
  input  wire logic                    frame_end,
  input  wire logic [`SPSS_PIX_W-1:0]  pix_data_in,
  input  wire logic                    frame_valid_in,
  input  wire logic                    line_valid_in,
  output logic [`SPSS_MODE_W-1:0]      mode_rdata,
  output logic                         pll_enable,
  output logic                         streaming,
  output logic                         soft_standby,
  output logic                         init_busy,
  output logic                         patch_rom_load,
  output logic                         one_time_prog_memory_load,
  output logic [`SPSS_PIX_W-1:0]       pix_data_out,
  output logic                         frame_valid_out,
  output logic                         line_valid_out,
  output logic                         pix_oe_n
);
  logic                    hrst_n_s;
  spss_state_t             state_r;
  spss_state_t             state_nxt;
  logic [`SPSS_CNT_W-1:0]  cnt_r;
  logic [`SPSS_CNT_W-1:0]  cnt_nxt;
  logic [`SPSS_MODE_W-1:0] mode_r;
  logic [`SPSS_MODE_W-1:0] mode_nxt;
  logic [`SPSS_PIX_W-1:0]  pix_r;
  logic [`SPSS_PIX_W-1:0]  pix_nxt;
  logic                    fv_r;
  logic                    fv_nxt;
  logic                    lv_r;
  logic                    lv_nxt;
  logic                    oe_n_r;
  logic                    oe_n_nxt;
  logic                    stream_bit;
  logic                    hold_rst;
  logic                    mode_open;
  logic                    pix_drive;
  logic                    in_init;
  logic                    in_standby;
  logic                    in_pll_wait;
  logic                    stream_on;
  logic                    init_done;
  logic                    lock_done;
  logic                    drain_done;
  logic                    pix_gate;
  logic [`SPSS_PIX_W-1:0]  pix_gated;

  spss_sync #(.W(1)) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .din     (hard_reset_n_pin),
    .dout    (hrst_n_s)
  );

  assign stream_bit = mode_r[`SPSS_STREAM_BIT];
  assign hold_rst    = !resetn || !hrst_n_s;
  assign mode_open   = (state_r != SPSS_HARD_RESET) && (state_r != SPSS_INIT);
  assign pix_drive   = (state_r != SPSS_HARD_RESET);

  // state decodes
  assign in_init     = (state_r == SPSS_INIT);
  assign in_standby  = (state_r == SPSS_STANDBY);
  assign in_pll_wait = (state_r == SPSS_PLL_WAIT);
  assign stream_on   = (state_r == SPSS_STREAMING) || (state_r == SPSS_DRAIN);

  // counter end points and drain end
  assign init_done   = (cnt_r == `SPSS_CNT_W'(INIT_CYC - 1));
  assign lock_done   = (cnt_r == `SPSS_CNT_W'(PLL_CYC - 1));
  assign drain_done  = stop_at_frame ? frame_end : row_end; // RQ9

  // mode register, refused during hard reset and init
  always_comb begin
    mode_nxt = mode_r;
    if (mode_we && mode_open) begin
      mode_nxt = mode_wdata;
    end
    if (hold_rst) begin
      mode_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    mode_r <= mode_nxt;
  end

  // sequencing state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      SPSS_HARD_RESET: begin
        cnt_nxt = '0;
        if (hrst_n_s) begin
          state_nxt = SPSS_INIT;
        end
      end
      SPSS_INIT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (init_done) begin // RQ5
          state_nxt = SPSS_STANDBY;
          cnt_nxt   = '0;
        end
      end
      SPSS_STANDBY: begin
        cnt_nxt = '0;
        if (stream_bit) begin
          state_nxt = SPSS_PLL_WAIT; // RQ6
        end
      end
      SPSS_PLL_WAIT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (!stream_bit) begin
          state_nxt = SPSS_STANDBY;
        end else if (lock_done) begin // RQ7
          state_nxt = SPSS_STREAMING;
          cnt_nxt   = '0;
        end
      end
      SPSS_STREAMING: begin
        if (!stream_bit) begin
          state_nxt = SPSS_DRAIN;
        end
      end
      SPSS_DRAIN: begin
        if (drain_done) begin
          state_nxt = SPSS_STANDBY; // RQ9
        end
      end
    endcase
    if (!hrst_n_s) begin
      state_nxt = SPSS_HARD_RESET;
      cnt_nxt   = '0;
    end
    if (!resetn) begin
      state_nxt = SPSS_HARD_RESET;
      cnt_nxt   = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    state_r <= state_nxt;
    cnt_r   <= cnt_nxt;
  end

  // per-bit gate keeps pixel lines quiet outside streaming
  assign pix_gate = stream_on && !hold_rst;

  genvar gi;
  generate
    for (gi = 0; gi < `SPSS_PIX_W; gi = gi + 1) begin : g_pix
      assign pix_gated[gi] = pix_data_in[gi] & pix_gate;
    end
  endgenerate

  // pixel output stage
  always_comb begin
    pix_nxt  = pix_gated;
    fv_nxt   = 1'b0;
    lv_nxt   = 1'b0;
    oe_n_nxt = 1'b1;
    if (pix_drive) begin
      oe_n_nxt = 1'b0;
    end
    if (stream_on) begin
      fv_nxt  = frame_valid_in;
      lv_nxt  = line_valid_in;
    end
    if (hold_rst) begin
      oe_n_nxt = 1'b1; // RQ4
      pix_nxt  = '0;
      fv_nxt   = 1'b0;
      lv_nxt   = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    pix_r  <= pix_nxt;
    fv_r   <= fv_nxt;
    lv_r   <= lv_nxt;
    oe_n_r <= oe_n_nxt;
  end

  assign mode_rdata                = mode_r;
  assign pll_enable                = in_pll_wait || stream_on; // RQ6
  assign streaming                 = stream_on;
  assign soft_standby              = in_standby;
  assign init_busy                 = in_init;
  assign patch_rom_load            = in_init;
  assign one_time_prog_memory_load = in_init;
  assign pix_data_out              = pix_r;
  assign frame_valid_out           = fv_r;
  assign line_valid_out            = lv_r;
  assign pix_oe_n                  = oe_n_r; // RQ4
endmodule
